// ==== rtl/cib_pkg.sv ====
/*
  Package for the charger serial register bank: bus addresses, register
  offsets, writable-bit masks, reset values, state encoding and carriers.
  Assumes nothing of its surroundings; imported whole by each module but the bus master model.
*/
package cib_pkg;

    // ------------------------------------------------------------------
    // serial bus device address bytes
    // ------------------------------------------------------------------
    localparam logic [7:0] DEV_ADDR_WRITE = 8'h28;
    localparam logic [7:0] DEV_ADDR_READ  = 8'h29;
    localparam logic [3:0] BITS_PER_BYTE  = 4'h8;

    // ------------------------------------------------------------------
    // register offsets (subaddresses)
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_REVISION_ID      = 8'h01;
    localparam logic [7:0] OFS_INPUT_SUPPLY     = 8'h02;
    localparam logic [7:0] OFS_VOLTAGE_THRESH   = 8'h05;
    localparam logic [7:0] OFS_FUNCTION_ONE     = 8'h07;
    localparam logic [7:0] OFS_FUNCTION_TWO     = 8'h08;
    localparam logic [7:0] OFS_INTERRUPT_ENABLE = 8'h09;
    localparam logic [7:0] OFS_INTERRUPT_FLAGS  = 8'h0A;
    localparam logic [7:0] OFS_CHARGE_STATE_ONE = 8'h0B;
    localparam logic [7:0] OFS_CHARGE_STATE_TWO = 8'h0C;
    localparam logic [7:0] OFS_FAULT_FLAGS      = 8'h0D;
    localparam logic [7:0] OFS_SHORT_DETECT     = 8'h10;

    // ------------------------------------------------------------------
    // reset values and implemented-bit masks (unused bits read zero)
    // ------------------------------------------------------------------
    localparam logic [7:0] RST_SETTING  = 8'h00;
    localparam logic [7:0] MASK_ALL     = 8'hFF;
    localparam logic [7:0] BYTE_ZERO    = 8'h00;
    localparam logic [7:0] SUB_STEP     = 8'h01;
    // revision value is arbitrary
    localparam logic [7:0] REVISION_DEFAULT = 8'h5A;

    // ------------------------------------------------------------------
    // serial engine states
    // ------------------------------------------------------------------
    typedef enum logic [3:0] {
        ST_IDLE,
        ST_ADDR,
        ST_ADDR_ACK,
        ST_SUB,
        ST_SUB_ACK,
        ST_WDATA,
        ST_WACK,
        ST_RDATA,
        ST_RACK
    } cib_state_type;

    // ------------------------------------------------------------------
    // carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] input_supply_settings;
        logic [7:0] voltage_threshold_settings;
        logic [7:0] function_settings_one;
        logic [7:0] function_settings_two;
        logic [7:0] interrupt_enable_mask;
        logic [7:0] short_detect_settings;
    } cib_settings_type;

    typedef struct packed {
        logic [7:0] interrupt_pending_flags;
        logic [7:0] charge_state_one;
        logic [7:0] charge_state_two;
    } cib_status_type;

endpackage

// ==== rtl/cib_sync.sv ====
/*
  Two-stage synchroniser for a group of levels from outside the clock
  domain. Assumes the caller reads only the second stage.
*/
`timescale 1ns/100ps
`default_nettype none

module cib_sync
    import cib_pkg::*;
#(
    parameter int WIDTH = 1
) (
    // clock and reset
    input  wire logic             clk_in,
    input  wire logic             sys_rst_in,
    // levels
    input  wire logic [WIDTH-1:0] async_in,
    input  wire logic [WIDTH-1:0] reset_value_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // first stage feeds only the second stage
    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            // same idle level as the second stage, so no false edge follows reset
            meta_reg <= reset_value_in;
        end else begin
            meta_reg <= async_in;
        end
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            sync_out <= reset_value_in;
        end else begin
            sync_out <= meta_reg;
        end
    end

endmodule

`default_nettype wire

// ==== rtl/cib_register_bank.sv ====
/*
  Charger serial register bank: a serial-bus slave on scl/sda with
  auto-incrementing subaddress, setting registers, status readback and
  write-one-to-clear fault flags.
  Assumes scl, sda and the supply comparator levels come from outside the
  clock domain, and that status and fault events come from logic on clk_in.
*/
// Overview of operation
// - supply below valid threshold resets all registers
// - no battery and zero supply resets registers
// - subaddress byte after address picks first register
// - acknowledge each received 8-bit byte
// - write advances subaddress per byte until stop
// - read first returns register at current subaddress
// - read advances subaddress per byte until stop
// - fault bit cleared by writing one or power
// - answer address byte 0x28 write, 0x29 read
`timescale 1ns/100ps
`default_nettype none

module cib_register_bank
    import cib_pkg::*;
#(
    parameter logic [7:0] REVISION   = REVISION_DEFAULT,
    parameter logic [7:0] FAULT_MASK = MASK_ALL,
    parameter logic [7:0] SET_MASK   = MASK_ALL
) (
    // clock and reset
    input  wire logic       clk_in,
    input  wire logic       sys_rst_in,
    // serial bus pins (sda open drain)
    input  wire logic       scl_in,
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe_out,
    // supply monitor levels
    input  wire logic       input_valid_threshold_in,
    input  wire logic       battery_present_in,
    input  wire logic       supply_zero_in,
    // charger side
    input  wire cib_status_type   status_in,
    input  wire logic [7:0]       fault_set_in,
    output var cib_settings_type  settings_out,
    output logic [7:0]      fault_flags_out
);

    // ------------------------------------------------------------------
    // input synchronisation
    // ------------------------------------------------------------------
    logic [4:0] sync_w;
    logic       scl_w;
    logic       sda_w;
    logic       scl_d_reg;
    logic       sda_d_reg;
    logic       supply_reset_w;

    cib_sync #(.WIDTH(5)) u_sync (
        .clk_in         (clk_in),
        .sys_rst_in     (sys_rst_in),
        .async_in       ({scl_in, sda_in, input_valid_threshold_in,
                          battery_present_in, supply_zero_in}),
        .reset_value_in (5'h1E),
        .sync_out       (sync_w)
    );

    assign scl_w = sync_w[4];
    assign sda_w = sync_w[3];
    // zero supply with no battery also wipes the bank
    assign supply_reset_w = ~sync_w[2]
                          | (~sync_w[1] & sync_w[0]);

    always_ff @(posedge clk_in) begin
        if (sys_rst_in) begin
            scl_d_reg <= 1'b1;
            sda_d_reg <= 1'b1;
        end else begin
            scl_d_reg <= scl_w;
            sda_d_reg <= sda_w;
        end
    end

    logic scl_rise_w;
    logic scl_fall_w;
    logic start_w;
    logic stop_w;

    assign scl_rise_w = scl_w & ~scl_d_reg;
    assign scl_fall_w = ~scl_w & scl_d_reg;
    assign start_w    = scl_w & scl_d_reg & sda_d_reg & ~sda_w;
    assign stop_w     = scl_w & scl_d_reg & ~sda_d_reg & sda_w;

    // ------------------------------------------------------------------
    // register storage
    // ------------------------------------------------------------------
    cib_settings_type settings_reg;
    logic [7:0]       fault_reg;
    logic [7:0]       sub_reg;
    logic             wr_pulse_reg;
    logic [7:0]       wr_data_reg;

    function automatic logic [7:0] read_mux(input logic [7:0] ofs);
        logic [7:0] v;
        v = BYTE_ZERO;
        if (ofs == OFS_REVISION_ID) begin
            v = REVISION;
        end else if (ofs == OFS_INPUT_SUPPLY) begin
            v = settings_reg.input_supply_settings;
        end else if (ofs == OFS_VOLTAGE_THRESH) begin
            v = settings_reg.voltage_threshold_settings;
        end else if (ofs == OFS_FUNCTION_ONE) begin
            v = settings_reg.function_settings_one;
        end else if (ofs == OFS_FUNCTION_TWO) begin
            v = settings_reg.function_settings_two;
        end else if (ofs == OFS_INTERRUPT_ENABLE) begin
            v = settings_reg.interrupt_enable_mask;
        end else if (ofs == OFS_INTERRUPT_FLAGS) begin
            v = status_in.interrupt_pending_flags;
        end else if (ofs == OFS_CHARGE_STATE_ONE) begin
            v = status_in.charge_state_one;
        end else if (ofs == OFS_CHARGE_STATE_TWO) begin
            v = status_in.charge_state_two;
        end else if (ofs == OFS_FAULT_FLAGS) begin
            v = fault_reg & FAULT_MASK;
        end else if (ofs == OFS_SHORT_DETECT) begin
            v = settings_reg.short_detect_settings;
        end
        // unmapped offsets fall through as zero
        return v;
    endfunction

    logic [7:0] rd_cur_w;
    logic [7:0] rd_nxt_w;

    // always_comb also follows the registers that read_mux reads directly
    always_comb begin
        rd_cur_w = read_mux(sub_reg);
        rd_nxt_w = read_mux(sub_reg + SUB_STEP);
    end

    always_ff @(posedge clk_in) begin
        if (sys_rst_in || supply_reset_w) begin
            settings_reg <= {6{RST_SETTING}};
        end else if (wr_pulse_reg) begin
            if (sub_reg == OFS_INPUT_SUPPLY) begin
                settings_reg.input_supply_settings <= wr_data_reg & SET_MASK;
            end else if (sub_reg == OFS_VOLTAGE_THRESH) begin
                settings_reg.voltage_threshold_settings <= wr_data_reg & SET_MASK;
            end else if (sub_reg == OFS_FUNCTION_ONE) begin
                settings_reg.function_settings_one <= wr_data_reg & SET_MASK;
            end else if (sub_reg == OFS_FUNCTION_TWO) begin
                settings_reg.function_settings_two <= wr_data_reg & SET_MASK;
            end else if (sub_reg == OFS_INTERRUPT_ENABLE) begin
                settings_reg.interrupt_enable_mask <= wr_data_reg & SET_MASK;
            end else if (sub_reg == OFS_SHORT_DETECT) begin
                settings_reg.short_detect_settings <= wr_data_reg & SET_MASK;
            end
            // read-only and unmapped targets ignore the byte
        end
    end

    // fault flags: a new event in the clearing cycle survives the clear
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || supply_reset_w) begin
            fault_reg <= RST_SETTING;
        end else if (wr_pulse_reg && sub_reg == OFS_FAULT_FLAGS) begin
            fault_reg <= ((fault_reg & ~wr_data_reg) | fault_set_in) & FAULT_MASK;
        end else begin
            fault_reg <= (fault_reg | fault_set_in) & FAULT_MASK;
        end
    end

    assign settings_out    = settings_reg;
    assign fault_flags_out = fault_reg;
    assign sda_out         = 1'b0;

    // ------------------------------------------------------------------
    // serial engine
    // ------------------------------------------------------------------
    cib_state_type state_reg;
    logic [3:0]    bit_cnt_reg;
    logic [7:0]    shift_reg;
    logic [7:0]    rd_shift_reg;
    logic          master_ack_reg;

    always_ff @(posedge clk_in) begin
        wr_pulse_reg <= 1'b0;
        if (sys_rst_in || supply_reset_w) begin
            state_reg      <= ST_IDLE;
            bit_cnt_reg    <= 4'h0;
            shift_reg      <= BYTE_ZERO;
            rd_shift_reg   <= BYTE_ZERO;
            master_ack_reg <= 1'b0;
            sub_reg        <= BYTE_ZERO;
            wr_data_reg    <= BYTE_ZERO;
            sda_oe_out     <= 1'b0;
            wr_pulse_reg   <= 1'b0;
        end else if (stop_w) begin
            state_reg  <= ST_IDLE;
            sda_oe_out <= 1'b0;
        end else if (start_w) begin
            // repeated start keeps the subaddress for a following read
            state_reg   <= ST_ADDR;
            bit_cnt_reg <= 4'h0;
            sda_oe_out  <= 1'b0;
        end else if (scl_rise_w) begin
            case (state_reg)
                ST_ADDR, ST_SUB, ST_WDATA: begin
                    shift_reg   <= {shift_reg[6:0], sda_w};
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                ST_RDATA: begin
                    bit_cnt_reg <= bit_cnt_reg + 4'h1;
                end
                ST_RACK: begin
                    master_ack_reg <= ~sda_w;
                end
                default: begin
                end
            endcase
        end else if (scl_fall_w) begin
            case (state_reg)
                ST_ADDR: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        if (shift_reg == DEV_ADDR_WRITE ||
                            shift_reg == DEV_ADDR_READ) begin
                            state_reg  <= ST_ADDR_ACK;
                            sda_oe_out <= 1'b1;
                        end else begin
                            state_reg <= ST_IDLE;
                        end
                    end
                end
                ST_ADDR_ACK: begin
                    bit_cnt_reg <= 4'h0;
                    if (shift_reg[0]) begin
                        // first byte out is the selected register
                        state_reg    <= ST_RDATA;
                        sda_oe_out   <= ~rd_cur_w[7];
                        rd_shift_reg <= {rd_cur_w[6:0], 1'b0};
                    end else begin
                        state_reg  <= ST_SUB;
                        sda_oe_out <= 1'b0;
                    end
                end
                ST_SUB: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        sub_reg    <= shift_reg;
                        state_reg  <= ST_SUB_ACK;
                        sda_oe_out <= 1'b1;
                    end
                end
                ST_SUB_ACK, ST_WACK: begin
                    state_reg   <= ST_WDATA;
                    bit_cnt_reg <= 4'h0;
                    sda_oe_out  <= 1'b0;
                    if (state_reg == ST_WACK) begin
                        sub_reg <= sub_reg + SUB_STEP;
                    end
                end
                ST_WDATA: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        wr_data_reg  <= shift_reg;
                        wr_pulse_reg <= 1'b1;
                        state_reg    <= ST_WACK;
                        sda_oe_out   <= 1'b1;
                    end
                end
                ST_RDATA: begin
                    if (bit_cnt_reg == BITS_PER_BYTE) begin
                        state_reg  <= ST_RACK;
                        sda_oe_out <= 1'b0;
                    end else begin
                        sda_oe_out   <= ~rd_shift_reg[7];
                        rd_shift_reg <= {rd_shift_reg[6:0], 1'b0};
                    end
                end
                ST_RACK: begin
                    sub_reg     <= sub_reg + SUB_STEP;
                    bit_cnt_reg <= 4'h0;
                    if (master_ack_reg) begin
                        state_reg    <= ST_RDATA;
                        sda_oe_out   <= ~rd_nxt_w[7];
                        rd_shift_reg <= {rd_nxt_w[6:0], 1'b0};
                    end else begin
                        // no acknowledge: release and wait for stop
                        state_reg <= ST_IDLE;
                    end
                end
                default: begin
                end
            endcase
        end
    end

endmodule

`default_nettype wire

// ==== tb/cib_sva.sv ====
/*
  Port checker for the charger serial register bank, bound to its top.
  Assumes sda_in carries the wired bus level and scl_in the master clock.
*/
`timescale 1ns/100ps
`default_nettype none

module cib_sva
    import cib_pkg::*;
#(
    parameter logic [7:0] FAULT_MASK = MASK_ALL
) (
    // clock and reset
    input wire logic             clk_in,
    input wire logic             sys_rst_in,
    // bus
    input wire logic             scl_in,
    input wire logic             sda_out,
    input wire logic             sda_oe_out,
    // supply monitor
    input wire logic             input_valid_threshold_in,
    input wire logic             battery_present_in,
    input wire logic             supply_zero_in,
    // charger side
    input wire logic [7:0]       fault_set_in,
    input wire cib_settings_type settings_out,
    input wire logic [7:0]       fault_flags_out
);
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);

    // ----------------
    // helper logic
    // ----------------
    logic       sup_ok;
    logic [7:0] set_d;
    logic [7:0] oe_cnt;
    assign sup_ok = input_valid_threshold_in && !(supply_zero_in && !battery_present_in);
    always_ff @(posedge clk_in) begin
        set_d <= fault_set_in & FAULT_MASK;
    end
    // length of one continuous pull on sda
    always_ff @(posedge clk_in) begin
        if (sys_rst_in || !sda_oe_out) begin
            oe_cnt <= 8'h00;
        end else if (oe_cnt != 8'hFF) begin
            oe_cnt <= oe_cnt + 8'h01;
        end
    end

    sequence supply_low_s;
        !input_valid_threshold_in [*5];
    endsequence
    sequence no_battery_s;
        (supply_zero_in && !battery_present_in) [*5];
    endsequence
    sequence quiet_s;
        (scl_in && sup_ok) [*6];
    endsequence

    // ----------------
    // assertions
    // ----------------
    a_reset_clears:
        assert property (disable iff (1'b0) sys_rst_in |=> settings_out == '0 && !sda_oe_out)
        else $error("reset left settings or sda drive");
    a_supply_low:
        assert property (supply_low_s |-> settings_out == '0 && fault_flags_out == 8'h00)
        else $error("low supply did not clear bank");
    a_no_battery:
        assert property (no_battery_s |-> settings_out == '0 && fault_flags_out == 8'h00)
        else $error("absent battery and zero supply did not clear bank");
    a_fault_sets:
        assert property (sup_ok [*4] ##0 fault_set_in != 8'h00 |=> (fault_flags_out & set_d) == set_d)
        else $error("fault event not latched");
    a_fault_no_spont:
        assert property ((fault_flags_out & ~$past(fault_flags_out) & ~set_d) == 8'h00)
        else $error("fault bit rose without event");
    a_quiet_stable:
        assert property (quiet_s |-> $stable(settings_out))
        else $error("settings changed on idle bus");
    a_oe_scl_high:
        assert property (scl_in [*3] |-> $stable(sda_oe_out))
        else $error("sda drive changed while scl high");
    a_drive_bounded:
        assert property (oe_cnt <= 8'h48)
        else $error("sda held low beyond one byte");
    a_open_drain:
        assert property (sda_out == 1'b0)
        else $error("sda drive value not low");
endmodule

bind cib_register_bank cib_sva #(.FAULT_MASK(FAULT_MASK)) u_sva (
    .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl_in), .sda_out(sda_out),
    .sda_oe_out(sda_oe_out), .input_valid_threshold_in(input_valid_threshold_in),
    .battery_present_in(battery_present_in), .supply_zero_in(supply_zero_in),
    .fault_set_in(fault_set_in), .settings_out(settings_out),
    .fault_flags_out(fault_flags_out)
);
`default_nettype wire

// ==== tb/cib_i2c_master.sv ====
/*
  Serial bus master model: 200 ns bit period, stepped on the system clock.
  Assumes the bench resolves sda from both pull-downs with a pull-up.
*/
`timescale 1ns/100ps
`default_nettype none

module cib_i2c_master (
    // timing reference
    input  wire logic clk_in,
    // bus
    input  wire logic sda_in,
    output logic      scl_out,
    output logic      sda_low_out
);
    initial begin
        scl_out = 1'b1;
        sda_low_out = 1'b0;
    end
    task automatic q();
        repeat (2) @(posedge clk_in);
        #1;
    endtask
    // sda moves only mid-low, sampled mid-high, so slave lag is covered
    task automatic bit_xfer(input logic b, output logic r);
        q();
        sda_low_out = !b;
        q();
        scl_out = 1'b1;
        q();
        r = sda_in;
        q();
        scl_out = 1'b0;
    endtask
    // also serves as repeated start
    task automatic start();
        q();
        sda_low_out = 1'b0;
        q();
        scl_out = 1'b1;
        q();
        sda_low_out = 1'b1;
        q();
        scl_out = 1'b0;
    endtask
    task automatic stop();
        q();
        sda_low_out = 1'b1;
        q();
        scl_out = 1'b1;
        q();
        sda_low_out = 1'b0;
        q();
    endtask
    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(d[i], r);
        end
        bit_xfer(1'b1, r);
        ack = !r;
    endtask
    task automatic rbyte(output logic [7:0] d, input logic last);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_xfer(1'b1, d[i]);
        end
        bit_xfer(last, r);
    endtask
endmodule
`default_nettype wire

// ==== tb/test_cib_register_bank.sv ====
/*
  Self-checking bench for the charger serial register bank.
  Assumes the master model and checker from the same folder.
*/
`timescale 1ns/100ps
`default_nettype none

module test_cib_register_bank;
    import cib_pkg::*;
    logic             clk_in = 1'b0;
    logic             sys_rst_in;
    logic             scl;
    logic             sda_low;
    logic             sda_oe;
    logic             valid;
    logic             batt;
    logic             zero;
    logic             ack;
    logic [7:0]       fault_set;
    logic [7:0]       faults;
    logic [7:0]       rd_buf [0:3];
    cib_status_type   status;
    cib_settings_type settings;
    wire logic        sda;
    int               n_fail = 0;
    int               checked = 0;
    int               cyc = 0;
    // pull-up on sda
    assign sda = !(sda_low || sda_oe);

    cib_register_bank dut (
        .clk_in(clk_in), .sys_rst_in(sys_rst_in), .scl_in(scl), .sda_in(sda),
        .sda_out(), .sda_oe_out(sda_oe), .input_valid_threshold_in(valid),
        .battery_present_in(batt), .supply_zero_in(zero), .status_in(status),
        .fault_set_in(fault_set), .settings_out(settings), .fault_flags_out(faults)
    );
    cib_i2c_master m (.clk_in(clk_in), .sda_in(sda), .scl_out(scl), .sda_low_out(sda_low));

    always #12.5 clk_in = ~clk_in;

    // ----------------
    // tasks
    // ----------------
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            n_fail++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        $display("checked=%0d n_fail=%0d", checked, n_fail);
        if (n_fail == 0 && checked > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic reg_wr(input logic [7:0] sub, input logic [7:0] d, input int n);
        logic       a;
        logic [7:0] v;
        v = d;
        m.start();
        m.wbyte(DEV_ADDR_WRITE, a);
        chk({7'h00, a}, 8'h01);
        m.wbyte(sub, a);
        chk({7'h00, a}, 8'h01);
        for (int k = 0; k < n; k++) begin
            m.wbyte(v, a);
            chk({7'h00, a}, 8'h01);
            v = v + 8'h11;
        end
        m.stop();
    endtask
    task automatic rd(input logic [7:0] sub, input int n);
        logic a;
        m.start();
        m.wbyte(DEV_ADDR_WRITE, a);
        m.wbyte(sub, a);
        m.start();
        m.wbyte(DEV_ADDR_READ, a);
        chk({7'h00, a}, 8'h01);
        for (int k = 0; k < n; k++) begin
            m.rbyte(rd_buf[k], k == n - 1);
        end
        m.stop();
    endtask

    // bus traffic needs some 3650 cycles
    always @(posedge clk_in) begin
        cyc++;
        if (cyc == 20000) begin
            n_fail++;
            summarize();
        end
    end

    // ----------------
    // sequence
    // ----------------
    initial begin
        sys_rst_in = 1'b1;
        valid = 1'b1;
        batt = 1'b1;
        zero = 1'b0;
        fault_set = 8'h00;
        status = '{8'h3C, 8'h81, 8'h42};
        tick(4);
        sys_rst_in = 1'b0;
        tick(4);
        rd(OFS_REVISION_ID, 2);
        chk(rd_buf[0], REVISION_DEFAULT);
        chk(rd_buf[1], RST_SETTING);
        reg_wr(OFS_FUNCTION_ONE, 8'hA1, 3);
        chk(settings.function_settings_one, 8'hA1);
        chk(settings.function_settings_two, 8'hB2);
        chk(settings.interrupt_enable_mask, 8'hC3);
        rd(OFS_FUNCTION_ONE, 4);
        chk(rd_buf[0], 8'hA1);
        chk(rd_buf[1], 8'hB2);
        chk(rd_buf[2], 8'hC3);
        chk(rd_buf[3], 8'h3C);
        reg_wr(OFS_VOLTAGE_THRESH, 8'h96, 1);
        chk(settings.voltage_threshold_settings, 8'h96);
        rd(OFS_CHARGE_STATE_ONE, 3);
        chk(rd_buf[0], 8'h81);
        chk(rd_buf[1], 8'h42);
        chk(rd_buf[2], BYTE_ZERO);
        // read-only target then writable neighbour; 0x03 is unmapped
        reg_wr(OFS_REVISION_ID, 8'hFF, 2);
        rd(OFS_REVISION_ID, 3);
        chk(rd_buf[0], REVISION_DEFAULT);
        chk(rd_buf[1], 8'h10);
        chk(rd_buf[2], BYTE_ZERO);
        fault_set = 8'hC3;
        tick(1);
        fault_set = 8'h00;
        tick(2);
        chk(faults, 8'hC3);
        reg_wr(OFS_FAULT_FLAGS, 8'h41, 1);
        chk(faults, 8'h82);
        rd(OFS_FAULT_FLAGS, 1);
        chk(rd_buf[0], 8'h82);
        m.start();
        m.wbyte(8'h30, ack);
        chk({7'h00, ack}, 8'h00);
        m.stop();
        valid = 1'b0;
        tick(8);
        valid = 1'b1;
        tick(8);
        chk(settings.input_supply_settings, RST_SETTING);
        chk(faults, 8'h00);
        reg_wr(OFS_SHORT_DETECT, 8'h5F, 1);
        chk(settings.short_detect_settings, 8'h5F);
        batt = 1'b0;
        zero = 1'b1;
        tick(8);
        batt = 1'b1;
        zero = 1'b0;
        tick(8);
        chk(settings.short_detect_settings, RST_SETTING);
        summarize();
    end
endmodule
`default_nettype wire
